// File: verif/smbs_host.sv
`timescale 1ns/1ps
module smbs_host (
	output logic scl,
	output logic sel,
	output logic sda,
	input wire logic dut_oe
);
	localparam realtime Q = 31.25;
	localparam realtime T_SU_STA = 4700;
	localparam realtime T_HD_STA = 4000;
	localparam realtime T_SU_STO = 4000;
	logic hdrv;
	// open drain with pull-up
	assign sda = !(hdrv || dut_oe);
	initial begin
		scl = 1;
		sel = 0;
		hdrv = 0;
	end
	task select(input logic v);
		#100;
		sel = v;
		#100;
	endtask : select
	task start;
		hdrv = 0;
		#Q scl = 1;
		#T_SU_STA hdrv = 1;
		#T_HD_STA scl = 0;
		#Q;
	endtask : start
	task bit_io(input logic b, output logic r);
		hdrv = !b;
		#Q scl = 1;
		#Q r = sda;
		#Q scl = 0;
		#Q;
	endtask : bit_io
	task xb(input logic [7:0] d, output logic [7:0] q, output logic ack);
		logic n;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], q[i]);
		end
		bit_io(1'b1, n);
		ack = !n;
	endtask : xb
	// released data, clock high, no stop
	task park;
		hdrv = 0;
		#Q scl = 1;
	endtask : park
	task stop;
		hdrv = 1;
		#Q scl = 1;
		#T_SU_STO hdrv = 0;
		#Q;
	endtask : stop
endmodule : smbs_host

// File: verif/smbs_slave_asserts.sv
`timescale 1ns/1ps
module smbs_slave_asserts #(
	parameter int HIGH_MAX_CYC = 5000,
	parameter int TIMEOUT_CYC = 2500000
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic mgmt_serial_clock,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic port_select_input,
	input wire logic [7:0] cfg_addr,
	input wire logic [7:0] cfg_wdata,
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	input wire logic [7:0] cfg_rdata,
	input wire logic bus_idle,
	input wire logic bus_timeout,
	input wire logic port_ready
);
	int hi_cnt;
	int lo_cnt;
	// run length of both lines high
	always_ff @(posedge clk) begin
		hi_cnt <= (mgmt_serial_clock && sda_in) ? hi_cnt + 1 : 0;
	end
	// run length of clock low
	always_ff @(posedge clk) begin
		lo_cnt <= mgmt_serial_clock ? 0 : lo_cnt + 1;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	sequence s_desel;
		!port_select_input [*4];
	endsequence
	sequence s_start_seen;
		$fell(bus_idle);
	endsequence
	property p_desel;
		s_desel |-> !sda_oe && !sda_out;
	endproperty
	property p_oe_sel;
		$rose(sda_oe) |-> $past(port_select_input, 3);
	endproperty
	property p_wr;
		cfg_wr |-> port_select_input && !cfg_rd ##1 !cfg_wr;
	endproperty
	property p_rd;
		cfg_rd |-> port_select_input ##1 !cfg_rd;
	endproperty
	property p_rdy;
		$past(reset_n) |-> port_ready;
	endproperty
	property p_start;
		s_start_seen |-> mgmt_serial_clock && !sda_in;
	endproperty
	property p_idle;
		$rose(bus_idle) |-> hi_cnt > 460;
	endproperty
	property p_to;
		bus_timeout |-> lo_cnt >= TIMEOUT_CYC - 4 && lo_cnt <= TIMEOUT_CYC + 4 ##1 !bus_timeout;
	endproperty
	property p_oe_low;
		$changed(sda_oe) && port_select_input |-> !mgmt_serial_clock;
	endproperty
	a_desel: assert property (p_desel) else $error("data driven while deselected");
	a_oe_sel: assert property (p_oe_sel) else $error("drive without select");
	a_wr: assert property (p_wr) else $error("bad write pulse");
	a_rd: assert property (p_rd) else $error("bad read pulse");
	a_rdy: assert property (p_rdy) else $error("port not ready");
	a_start: assert property (p_start) else $error("idle left without start");
	a_idle: assert property (p_idle) else $error("idle too early");
	a_to: assert property (p_to) else $error("timeout at wrong count");
	a_oe_low: assert property (p_oe_low) else $error("data moved with clock high");
endmodule : smbs_slave_asserts

bind smbs_slave smbs_slave_asserts #(.HIGH_MAX_CYC(HIGH_MAX_CYC), .TIMEOUT_CYC(TIMEOUT_CYC)) u_chk (
	.clk(clk), .reset_n(reset_n), .mgmt_serial_clock(mgmt_serial_clock), .sda_in(sda_in),
	.sda_out(sda_out), .sda_oe(sda_oe), .port_select_input(port_select_input),
	.cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
	.cfg_rdata(cfg_rdata), .bus_idle(bus_idle), .bus_timeout(bus_timeout),
	.port_ready(port_ready));

// File: verif/smbs_slave_bench.sv
`timescale 1ns/1ps
module smbs_slave_bench;
	import smbs_pkg::*;
	typedef struct packed {logic [7:0] a; logic [7:0] r; logic [7:0] d; logic s; logic ok;} smbs_row_t;
	smbs_row_t rows [6] = '{'{8'hAC, 8'h03, 8'h5A, 1, 1}, '{8'hAC, 8'h00, 8'hFF, 1, 1},
		'{8'hAC, 8'hFF, 8'h00, 1, 1}, '{8'hAE, 8'h04, 8'h11, 1, 0},
		'{8'h56, 8'h04, 8'h22, 1, 0}, '{8'hAC, 8'h05, 8'h33, 0, 0}};
	logic clk = 0;
	logic reset_n = 0;
	logic scl, sel, sda, sda_out, sda_oe, cfg_wr, cfg_rd, bus_idle, bus_timeout, port_ready, x;
	logic [7:0] cfg_addr, cfg_wdata, last_a, last_d, q, n;
	logic [7:0] cfg_rdata = 8'h00;
	logic [7:0] wr_cnt = 8'h00;
	logic [7:0] to_cnt = 8'h00;
	logic [7:0] mem [256];
	logic [2:0] ak;
	int error_cnt = 0;
	int checks = 0;
	int cyc = 0;
	smbs_slave #(.HIGH_MAX_CYC(600), .TIMEOUT_CYC(2000)) uut (.clk(clk), .reset_n(reset_n),
		.mgmt_serial_clock(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
		.port_select_input(sel), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_wr(cfg_wr),
		.cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata), .bus_idle(bus_idle), .bus_timeout(bus_timeout),
		.port_ready(port_ready));
	smbs_host h (.scl(scl), .sel(sel), .sda(sda), .dut_oe(sda_oe));
	initial begin
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		cfg_rdata <= mem[cfg_addr];
		if (cfg_wr) begin
			mem[cfg_addr] <= cfg_wdata;
			last_a <= cfg_addr;
			last_d <= cfg_wdata;
			wr_cnt <= wr_cnt + 8'h01;
		end
		if (bus_timeout) to_cnt <= to_cnt + 8'h01;
		if (cyc == 60000) begin
			error_cnt++;
			report_and_stop();
		end
	end
	task chk(input string nm, input logic [7:0] e, input logic [7:0] v);
		checks++;
		if (v !== e) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, e, v);
		end
	endtask : chk
	task step(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : step
	task wait_idle;
		for (int i = 0; i < 2000 && bus_idle !== 1'b1; i++) @(posedge clk);
	endtask : wait_idle
	task txn(input smbs_row_t w, input logic rd);
		h.select(w.s);
		h.start();
		h.xb(w.a, q, ak[2]);
		h.xb(w.r, q, ak[1]);
		if (rd) begin
			h.start();
			h.xb(w.a | 8'h01, q, ak[0]);
			h.xb(8'hFF, q, x);
		end else h.xb(w.d, q, ak[0]);
		h.stop();
		h.select(0);
		wait_idle();
	endtask : txn
	task report_and_stop;
		$display("checks %0d error_cnt %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : report_and_stop
	initial begin
		step(4);
		chk("port_ready in reset", 8'h00, {7'h0, port_ready});
		chk("bus_idle in reset", 8'h01, {7'h0, bus_idle});
		@(posedge clk) reset_n <= 1;
		step(1);
		chk("port_ready", 8'h01, {7'h0, port_ready});
		step(3);
		foreach (rows[i]) begin
			n = wr_cnt;
			txn(rows[i], 0);
			chk("write acks", {5'h0, {3{rows[i].ok}}}, {5'h0, ak});
			chk("write count", n + {7'h0, rows[i].ok}, wr_cnt);
			if (rows[i].ok) begin
				chk("cfg_addr", rows[i].r, last_a);
				chk("cfg_wdata", rows[i].d, last_d);
				txn(rows[i], 1);
				chk("read acks", 8'h07, {5'h0, ak});
				chk("read data", rows[i].d, q);
			end
		end
		h.select(1);
		h.start();
		h.xb(8'hAC, q, x);
		h.stop();
		step(440);
		chk("idle before free time", 8'h00, {7'h0, bus_idle});
		step(40);
		chk("idle after free time", 8'h01, {7'h0, bus_idle});
		h.start();
		chk("idle after start", 8'h00, {7'h0, bus_idle});
		h.park();
		step(540);
		chk("idle before high max", 8'h00, {7'h0, bus_idle});
		step(80);
		chk("idle after high max", 8'h01, {7'h0, bus_idle});
		h.start();
		step(1980);
		chk("no early timeout", 8'h00, to_cnt);
		step(40);
		chk("timeout pulses", 8'h01, to_cnt);
		h.stop();
		h.select(0);
		@(posedge clk) reset_n <= 0;
		step(3);
		chk("port_ready in mid reset", 8'h00, {7'h0, port_ready});
		chk("bus_idle in mid reset", 8'h01, {7'h0, bus_idle});
		chk("sda_oe in mid reset", 8'h00, {7'h0, sda_oe});
		@(posedge clk) reset_n <= 1;
		step(1);
		chk("port_ready after mid reset", 8'h01, {7'h0, port_ready});
		txn(rows[0], 0);
		chk("acks after mid reset", 8'h07, {5'h0, ak});
		report_and_stop();
	end
endmodule : smbs_slave_bench

// File: verilog/smbs_pkg.sv
package smbs_pkg;

	localparam int CLK_PERIOD_PS = 10000;

	// fixed slave address, shared by every instance
	localparam logic [6:0] SLAVE_ADDR = 7'h56;
	localparam logic [7:0] WRITE_ADDR_BYTE = 8'hAC;

	// bus free time after stop, least
	localparam int T_BUF_NS = 4700;
	localparam int T_BUF_CYC = (T_BUF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// longest period with clock and data both high before the bus counts as idle
	localparam int T_HIGH_MAX_US = 50;
	localparam int T_HIGH_MAX_CYC = (T_HIGH_MAX_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// clock-low timeout window, least figure used
	localparam int T_TIMEOUT_MIN_MS = 25;
	localparam int T_TIMEOUT_MAX_MS = 35;
	localparam longint T_TIMEOUT_PS = longint'(T_TIMEOUT_MIN_MS) * 64'd1000000000;
	localparam int T_TIMEOUT_CYC = int'((T_TIMEOUT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

	// counter widths
	localparam int HI_CNT_W = 13;
	localparam int LO_CNT_W = 22;
	localparam int BIT_CNT_W = 4;

	// bit positions within a byte-plus-acknowledge frame
	localparam logic [3:0] BIT_LAST_DATA = 4'h7;
	localparam logic [3:0] BIT_ACK = 4'h8;

	// values after reset
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [3:0] BIT_CNT_RESET = 4'h0;

	typedef enum logic [2:0] {
		SMBS_IDLE,
		SMBS_ADDR,
		SMBS_REG,
		SMBS_DATA,
		SMBS_TX,
		SMBS_IGNORE
	} smbs_state_t;

endpackage : smbs_pkg

// File: verilog/smbs_slave.sv
`timescale 1ns/1ps

module smbs_slave
	import smbs_pkg::*;
#(
	parameter int HIGH_MAX_CYC = T_HIGH_MAX_CYC,
	parameter int TIMEOUT_CYC = T_TIMEOUT_CYC
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic mgmt_serial_clock,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic port_select_input,
	output logic [7:0] cfg_addr,
	output logic [7:0] cfg_wdata,
	output logic cfg_wr,
	output logic cfg_rd,
	input wire logic [7:0] cfg_rdata,
	output logic bus_idle,
	output logic bus_timeout,
	output logic port_ready
);

	if (HIGH_MAX_CYC < T_BUF_CYC || HIGH_MAX_CYC >= (1 << HI_CNT_W)) begin : g_hi_range
		$error("HIGH_MAX_CYC out of range");
	end
	if (TIMEOUT_CYC < 2 || TIMEOUT_CYC >= (1 << LO_CNT_W)) begin : g_lo_range
		$error("TIMEOUT_CYC out of range");
	end

	localparam logic [HI_CNT_W-1:0] HI_MAX = HI_CNT_W'(HIGH_MAX_CYC);
	localparam logic [HI_CNT_W-1:0] HI_BUF = HI_CNT_W'(T_BUF_CYC);
	localparam logic [LO_CNT_W-1:0] LO_MAX = LO_CNT_W'(TIMEOUT_CYC);

	// link domain: bits shifted in on the serial clock's rising edge
	logic [7:0] link_shift_reg;

	always_ff @(posedge mgmt_serial_clock) begin
		link_shift_reg <= {link_shift_reg[6:0], sda_in};
	end

	// pin synchronisers
	logic scl_meta_reg;
	logic scl_sync_reg;
	logic scl_dly_reg;
	logic sda_meta_reg;
	logic sda_sync_reg;
	logic sda_dly_reg;
	logic sel_meta_reg;
	logic sel_sync_reg;
	logic scl_rise_reg;

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			scl_meta_reg <= 1'b1;
			scl_sync_reg <= 1'b1;
			scl_dly_reg <= 1'b1;
			sda_meta_reg <= 1'b1;
			sda_sync_reg <= 1'b1;
			sda_dly_reg <= 1'b1;
			sel_meta_reg <= 1'b0;
			sel_sync_reg <= 1'b0;
			scl_rise_reg <= 1'b0;
		end else begin
			scl_meta_reg <= mgmt_serial_clock;
			scl_sync_reg <= scl_meta_reg;
			scl_dly_reg <= scl_sync_reg;
			sda_meta_reg <= sda_in;
			sda_sync_reg <= sda_meta_reg;
			sda_dly_reg <= sda_sync_reg;
			sel_meta_reg <= port_select_input;
			sel_sync_reg <= sel_meta_reg;
			scl_rise_reg <= scl_sync_reg & ~scl_dly_reg;
		end
	end

	logic start_det;
	logic stop_det;
	logic scl_fall;
	logic bit_evt;

	// start and stop seen on the synchronised pins
	assign start_det = scl_sync_reg & scl_dly_reg & sda_dly_reg & ~sda_sync_reg;
	assign stop_det = scl_sync_reg & scl_dly_reg & ~sda_dly_reg & sda_sync_reg;
	assign scl_fall = scl_dly_reg & ~scl_sync_reg;
	// link byte has long settled by the time the delayed rise arrives
	assign bit_evt = scl_rise_reg;

	// bus-high and clock-low timers
	logic [HI_CNT_W-1:0] hi_cnt_reg;
	logic [LO_CNT_W-1:0] lo_cnt_reg;
	logic stop_seen_reg;
	logic hi_timeout;
	logic lo_timeout;

	assign hi_timeout = (hi_cnt_reg == HI_MAX);
	assign lo_timeout = (lo_cnt_reg == LO_MAX);

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			hi_cnt_reg <= '0;
		end else if (!(scl_sync_reg && sda_sync_reg)) begin
			hi_cnt_reg <= '0;
		end else if (!hi_timeout) begin
			hi_cnt_reg <= hi_cnt_reg + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			lo_cnt_reg <= '0;
		end else if (scl_sync_reg) begin
			lo_cnt_reg <= '0;
		end else if (!lo_timeout) begin
			lo_cnt_reg <= lo_cnt_reg + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			stop_seen_reg <= 1'b0;
		end else if (start_det) begin
			stop_seen_reg <= 1'b0;
		end else if (stop_det) begin
			stop_seen_reg <= 1'b1;
		end
	end

	logic idle_next;

	always_comb begin
		idle_next = bus_idle;
		if (start_det) begin
			idle_next = 1'b0;
		end else if (stop_seen_reg && hi_cnt_reg >= HI_BUF) begin
			idle_next = 1'b1;
		end else if (hi_timeout) begin
			idle_next = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			bus_idle <= 1'b1;
		end else begin
			bus_idle <= idle_next;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			bus_timeout <= 1'b0;
		end else begin
			bus_timeout <= !scl_sync_reg && (lo_cnt_reg == LO_MAX - 1'b1);
		end
	end

	// ready right after reset release, no low-power gating anywhere
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			port_ready <= 1'b0;
		end else begin
			port_ready <= 1'b1;
		end
	end

	// protocol engine
	smbs_state_t state_reg;
	smbs_state_t state_next;
	logic [BIT_CNT_W-1:0] bit_cnt_reg;
	logic ack_pend_reg;
	logic ack_pend_next;
	logic [7:0] tx_byte_reg;
	logic abort;
	logic [7:0] rx_byte;

	assign rx_byte = link_shift_reg;
	// deselect, timeouts and idle all drop the transaction
	// a fresh start outranks the long-idle timeout
	assign abort = !sel_sync_reg || lo_timeout
		|| (hi_timeout && !start_det);

	function automatic logic addr_match(input logic [7:0] b);
		addr_match = (b[7:1] == SLAVE_ADDR);
	endfunction : addr_match

	always_comb begin
		state_next = state_reg;
		ack_pend_next = ack_pend_reg;
		if (abort) begin
			state_next = SMBS_IDLE;
			ack_pend_next = 1'b0;
		end else if (start_det) begin
			state_next = SMBS_ADDR;
			ack_pend_next = 1'b0;
		end else if (stop_det) begin
			state_next = SMBS_IDLE;
			ack_pend_next = 1'b0;
		end else if (bit_evt && bit_cnt_reg == BIT_LAST_DATA) begin
			ack_pend_next = 1'b0;
			case (state_reg)
				SMBS_ADDR: begin
					if (rx_byte == WRITE_ADDR_BYTE) begin
						state_next = SMBS_REG;
						ack_pend_next = 1'b1;
					end else if (addr_match(rx_byte) && rx_byte[0]) begin
						state_next = SMBS_TX;
						ack_pend_next = 1'b1;
					end else begin
						state_next = SMBS_IGNORE;
					end
				end
				SMBS_REG: begin
					state_next = SMBS_DATA;
					ack_pend_next = 1'b1;
				end
				SMBS_DATA: begin
					state_next = SMBS_IGNORE;
					ack_pend_next = 1'b1;
				end
				default: begin
					ack_pend_next = 1'b0;
				end
			endcase
		end else if (bit_evt && bit_cnt_reg == BIT_ACK) begin
			ack_pend_next = 1'b0;
			if (state_reg == SMBS_TX && rx_byte[0]) begin
				state_next = SMBS_IGNORE;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state_reg <= SMBS_IDLE;
			ack_pend_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			ack_pend_reg <= ack_pend_next;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			bit_cnt_reg <= BIT_CNT_RESET;
		end else if (abort || start_det || stop_det) begin
			bit_cnt_reg <= BIT_CNT_RESET;
		end else if (bit_evt) begin
			bit_cnt_reg <= (bit_cnt_reg == BIT_ACK) ? BIT_CNT_RESET : bit_cnt_reg + 1'b1;
		end
	end

	// register-side strobes and data
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			cfg_addr <= BYTE_RESET;
			cfg_wdata <= BYTE_RESET;
			cfg_wr <= 1'b0;
			cfg_rd <= 1'b0;
		end else begin
			cfg_wr <= 1'b0;
			cfg_rd <= 1'b0;
			if (!abort && !start_det && !stop_det && bit_evt && bit_cnt_reg == BIT_LAST_DATA) begin
				if (state_reg == SMBS_REG) begin
					cfg_addr <= rx_byte;
				end
				if (state_reg == SMBS_DATA) begin
					cfg_wdata <= rx_byte;
					cfg_wr <= 1'b1;
				end
				if (state_reg == SMBS_ADDR && addr_match(rx_byte) && rx_byte[0]) begin
					cfg_rd <= 1'b1;
				end
			end
		end
	end

	// read data taken one cycle after the read strobe
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			tx_byte_reg <= BYTE_RESET;
		end else if (cfg_rd) begin
			tx_byte_reg <= cfg_rdata;
		end
	end

	// data line drive, set on clock falling edges, released at once on abort, start or stop
	logic oe_next;

	always_comb begin
		oe_next = sda_oe;
		if (abort || start_det || stop_det) begin
			oe_next = 1'b0;
		end else if (scl_fall) begin
			if (bit_cnt_reg == BIT_ACK) begin
				oe_next = ack_pend_reg;
			end else if (state_reg == SMBS_TX) begin
				oe_next = ~tx_byte_reg[3'(BIT_LAST_DATA - bit_cnt_reg)];
			end else begin
				oe_next = 1'b0;
			end
		end
	end

	// never holds the clock low, so no stretch at all
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			sda_oe <= 1'b0;
			sda_out <= 1'b0;
		end else begin
			sda_oe <= oe_next && sel_sync_reg;
			sda_out <= 1'b0;
		end
	end

endmodule : smbs_slave
